// *** inc/ctr_pkg.sv ***
// Package for the charger telemetry register bank
package ctr_pkg;

    // Register sub-addresses
    localparam logic [7:0] ADDR_BAT_LO    = 8'h01;
    localparam logic [7:0] ADDR_BAT_HI    = 8'h02;
    localparam logic [7:0] ADDR_IN_LO     = 8'h03;
    localparam logic [7:0] ADDR_IN_HI     = 8'h04;
    localparam logic [7:0] ADDR_LIM_EN    = 8'h0d;
    localparam logic [7:0] ADDR_SET_FIRST = 8'h1a;
    localparam logic [7:0] ADDR_SET_LAST  = 8'h2d;
    localparam logic [7:0] ADDR_LIM_ALERT = 8'h36;
    localparam logic [7:0] ADDR_STATUS    = 8'h39;
    localparam logic [7:0] ADDR_BAT_V     = 8'h3a;
    localparam logic [7:0] ADDR_IN_V      = 8'h3b;
    localparam logic [7:0] ADDR_SYS_V     = 8'h3c;
    localparam logic [7:0] ADDR_BAT_I     = 8'h3d;
    localparam logic [7:0] ADDR_IN_I      = 8'h3e;
    localparam logic [7:0] ADDR_CHIP_TEMP = 8'h3f;
    localparam logic [7:0] ADDR_NTC       = 8'h40;
    localparam logic [7:0] ADDR_SERIES_R  = 8'h41;
    localparam logic [7:0] ADDR_ZONE      = 8'h42;
    localparam logic [7:0] ADDR_TYPE_CNT  = 8'h43;
    localparam logic [7:0] ADDR_ICHG_CODE = 8'h44;
    localparam logic [7:0] ADDR_VCHG_CODE = 8'h45;
    localparam logic [7:0] ADDR_ILIM_CODE = 8'h46;
    localparam logic [7:0] ADDR_BAT_FILT  = 8'h47;
    localparam logic [7:0] ADDR_R_CURRENT = 8'h48;
    localparam logic [7:0] ADDR_RESERVED  = 8'h49;
    localparam logic [7:0] ADDR_READY     = 8'h4a;

    // Field positions of limit enables and alert flags
    localparam int BIT_BAT_LO = 11;
    localparam int BIT_BAT_HI = 10;
    localparam int BIT_IN_LO  = 9;
    localparam int BIT_IN_HI  = 8;

    // Status bit positions
    localparam int BIT_IN_OVER        = 3;
    localparam int BIT_IN_ABOVE_BAT   = 2;
    localparam int BIT_REG_SW_LOCK    = 1;
    localparam int BIT_REG_MEAS_LOCK  = 0;

    // Type and count field positions
    localparam int CHEM_LSB  = 8;
    localparam int CELLS_LSB = 0;

    // Reset values
    localparam logic [15:0] RST_LIMIT     = 16'h0000;
    localparam logic [15:0] RST_LIMIT_HI  = 16'h7fff;
    localparam logic [15:0] RST_LIM_EN    = 16'h0000;
    localparam logic [15:0] RST_SETTING   = 16'h0000;
    localparam logic [15:0] UNMAPPED_DATA = 16'h0000;

    // Number of charger setting words
    localparam int N_SETTINGS = 20;

    // Measurement results from the converter
    typedef struct packed {
        logic [15:0] bat_v;
        logic [15:0] in_v;
        logic [15:0] sys_v;
        logic [15:0] bat_i;
        logic [15:0] in_i;
        logic [15:0] chip_temp;
        logic [15:0] therm_ratio;
        logic [15:0] series_r;
        logic [15:0] bat_filt;
    } ctr_meas_t;

    // Live conditions of the charger
    typedef struct packed {
        logic       in_over;
        logic       input_above_battery;
        logic       regulator_above_switch_lockout;
        logic       regulator_above_measure_lockout;
        logic [2:0] battery_temperature_zone;
        logic [3:0] chem;
        logic [3:0] cells;
        logic [4:0] charge_current_code;
        logic [5:0] charge_voltage_code;
        logic [5:0] input_limit_code;
    } ctr_cond_t;

    // Register access from the serial port engine
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } ctr_req_t;

endpackage

// *** rtl/ctr_bank.sv ***
// Telemetry register bank with limit alerts for a battery charger
//
// Functional notes
// - Hold programmable battery voltage low/high limits
// - Hold programmable input voltage low/high limits
// - Battery voltage result at own sub-address
// - Battery current signed, charge positive
// - Die temperature signed code readout
// - Thermistor ratio signed code readout
// - Three-bit zone, valid with zone enable
// - Chemistry 11:8, cells 3:0, 7:4 reserved
// - Read-only charge, voltage, limit control codes
// - Separate filtered battery voltage result
// - Latch current used for resistance calculation
// - Report calculated series resistance
// - Ready flag bit 0 once converter ready
// - Settings writable only for programmable chemistry
// - Status bit 3: input overvoltage
// - Status bit 2: input above battery
// - Status bit 1: regulator above switch lockout
// - Status bit 0: regulator above measure lockout
// - Status word mirrors conditions, never latches
// - Enabled limit breach sets alert once ready flag set, raises line
`timescale 1ns/1ps

module ctr_bank
    import ctr_pkg::*;
#(
    parameter int N_SET = N_SETTINGS
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    // Register access
    input  wire ctr_req_t    req,
    output logic [15:0]      rdata,
    output logic             rvalid,
    // Converter side
    input  wire ctr_meas_t   meas,
    input  wire logic        meas_done,
    input  wire logic        meas_ready,
    input  wire logic        series_r_done,
    input  wire logic        temperature_zone_charging_enable,
    input  wire logic        programmable_chem,
    input  wire ctr_cond_t   cond,
    // Alert line
    output logic             alert
);

    // ************************************************************
    // Storage
    // ************************************************************
    logic [15:0] battery_voltage_low_limit;
    logic [15:0] battery_voltage_high_limit;
    logic [15:0] input_voltage_low_limit;
    logic [15:0] input_voltage_high_limit;
    logic [15:0] limit_enable;
    logic [15:0] limit_alert;
    logic [15:0] settings [N_SET];
    ctr_meas_t   result;
    logic [15:0] resistance_calc_current;
    logic        telemetry_ready_flag;
    logic [15:0] next_rdata;
    logic [15:0] next_alert_set;

    function automatic logic in_settings(input logic [7:0] a);
        in_settings = (a >= ADDR_SET_FIRST) && (a <= ADDR_SET_LAST);
    endfunction

    function automatic logic wr_hit(input ctr_req_t r,
                                    input logic [7:0] a);
        wr_hit = r.wr && (r.addr == a);
    endfunction

    // ************************************************************
    // Alert limits
    // ************************************************************
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            battery_voltage_low_limit  <= RST_LIMIT;
            battery_voltage_high_limit <= RST_LIMIT_HI;
            input_voltage_low_limit    <= RST_LIMIT;
            input_voltage_high_limit   <= RST_LIMIT_HI;
            limit_enable               <= RST_LIM_EN;
        end else begin
            if (wr_hit(req, ADDR_BAT_LO))
                battery_voltage_low_limit <= req.wdata;
            if (wr_hit(req, ADDR_BAT_HI))
                battery_voltage_high_limit <= req.wdata;
            if (wr_hit(req, ADDR_IN_LO))
                input_voltage_low_limit <= req.wdata;
            if (wr_hit(req, ADDR_IN_HI))
                input_voltage_high_limit <= req.wdata;
            if (wr_hit(req, ADDR_LIM_EN))
                limit_enable <= req.wdata;
        end
    end

    // ************************************************************
    // Charger setting words
    // ************************************************************
    generate
        for (genvar i = 0; i < N_SET; i++) begin : g_set
            localparam logic [7:0] A = ADDR_SET_FIRST + 8'(i);
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    settings[i] <= RST_SETTING;
                end else if (wr_hit(req, A) && programmable_chem) begin
                    settings[i] <= req.wdata;
                end
            end
        end
    endgenerate

    // ************************************************************
    // Measurement results
    // ************************************************************
    // Results update as one snapshot so a read never mixes samples
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            result <= '0;
        end else if (meas_done) begin
            result <= meas;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            resistance_calc_current <= 16'h0000;
        end else if (series_r_done) begin
            resistance_calc_current <= result.bat_i;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            telemetry_ready_flag <= 1'b0;
        end else begin
            telemetry_ready_flag <= meas_ready;
        end
    end

    // ************************************************************
    // Limit comparison and alerts
    // ************************************************************
    // Compare on the fresh sample; warm-up samples are ignored
    always_comb begin
        next_alert_set = 16'h0000;
        if (meas_done && telemetry_ready_flag) begin
            next_alert_set[BIT_BAT_LO] = limit_enable[BIT_BAT_LO] &&
                ($signed(meas.bat_v) <
                 $signed(battery_voltage_low_limit));
            next_alert_set[BIT_BAT_HI] = limit_enable[BIT_BAT_HI] &&
                ($signed(meas.bat_v) >
                 $signed(battery_voltage_high_limit));
            next_alert_set[BIT_IN_LO] = limit_enable[BIT_IN_LO] &&
                ($signed(meas.in_v) <
                 $signed(input_voltage_low_limit));
            next_alert_set[BIT_IN_HI] = limit_enable[BIT_IN_HI] &&
                ($signed(meas.in_v) >
                 $signed(input_voltage_high_limit));
        end
    end

    // Writing 0 clears a flag; a new event in that cycle wins
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            limit_alert <= 16'h0000;
        end else begin
            if (wr_hit(req, ADDR_LIM_ALERT))
                limit_alert <= (limit_alert & req.wdata & limit_enable)
                               | next_alert_set;
            else
                limit_alert <= (limit_alert & limit_enable)
                               | next_alert_set;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            alert <= 1'b0;
        end else begin
            alert <= |((limit_alert & limit_enable) | next_alert_set);
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    always_comb begin
        next_rdata = UNMAPPED_DATA;
        case (req.addr)
            ADDR_BAT_LO:    next_rdata = battery_voltage_low_limit;
            ADDR_BAT_HI:    next_rdata = battery_voltage_high_limit;
            ADDR_IN_LO:     next_rdata = input_voltage_low_limit;
            ADDR_IN_HI:     next_rdata = input_voltage_high_limit;
            ADDR_LIM_EN:    next_rdata = limit_enable;
            ADDR_LIM_ALERT: next_rdata = limit_alert;
            ADDR_STATUS: begin
                // Live mirror, no latching
                next_rdata[BIT_IN_OVER] = cond.in_over;
                next_rdata[BIT_IN_ABOVE_BAT] =
                    cond.input_above_battery;
                next_rdata[BIT_REG_SW_LOCK] =
                    cond.regulator_above_switch_lockout;
                next_rdata[BIT_REG_MEAS_LOCK] =
                    cond.regulator_above_measure_lockout;
            end
            ADDR_BAT_V:     next_rdata = result.bat_v;
            ADDR_IN_V:      next_rdata = result.in_v;
            ADDR_SYS_V:     next_rdata = result.sys_v;
            ADDR_BAT_I:     next_rdata = result.bat_i;
            ADDR_IN_I:      next_rdata = result.in_i;
            ADDR_CHIP_TEMP: next_rdata = result.chip_temp;
            ADDR_NTC:       next_rdata = result.therm_ratio;
            ADDR_SERIES_R:  next_rdata = result.series_r;
            ADDR_ZONE: begin
                // Zone only means something with zone charging on
                if (temperature_zone_charging_enable)
                    next_rdata[2:0] = cond.battery_temperature_zone;
            end
            ADDR_TYPE_CNT: begin
                next_rdata[CHEM_LSB +: 4]  = cond.chem;
                next_rdata[CELLS_LSB +: 4] = cond.cells;
            end
            ADDR_ICHG_CODE: next_rdata[4:0] = cond.charge_current_code;
            ADDR_VCHG_CODE: next_rdata[5:0] = cond.charge_voltage_code;
            ADDR_ILIM_CODE: next_rdata[5:0] = cond.input_limit_code;
            ADDR_BAT_FILT:  next_rdata = result.bat_filt;
            ADDR_R_CURRENT: next_rdata = resistance_calc_current;
            ADDR_READY:     next_rdata[0] = telemetry_ready_flag;
            default: begin
                if (in_settings(req.addr))
                    next_rdata = settings[5'(req.addr - ADDR_SET_FIRST)];
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata  <= 16'h0000;
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd;
            if (req.rd)
                rdata <= next_rdata;
        end
    end

endmodule

// *** tb/ctr_bank_assertions.sv ***
// Port-level checks for the telemetry register bank
`timescale 1ns/1ps
module ctr_bank_checker
    import ctr_pkg::*;
#(
    parameter int N_SET = N_SETTINGS
) (
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire ctr_req_t    req,
    input wire logic [15:0] rdata,
    input wire logic        rvalid,
    input wire logic        meas_done,
    input wire logic        meas_ready,
    input wire logic        temperature_zone_charging_enable,
    input wire ctr_cond_t   cond,
    input wire logic        alert
);
    // ****************************************
    // Read answers and alert causes
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    logic [1:0] up_cnt;
    // Ready history is only trusted a few edges after reset
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            up_cnt <= 2'h0;
        end else if (up_cnt != 2'h3) begin
            up_cnt <= up_cnt + 2'h1;
        end
    end
    sequence s_read(logic [7:0] a);
        req.rd && req.addr == a;
    endsequence
    a_read_answer: assert property (req.rd |=> rvalid)
        else $error("read not answered");
    a_no_spurious: assert property (!req.rd |=> !rvalid)
        else $error("answer without read");
    a_status_live: assert property (s_read(ADDR_STATUS)
        |=> rdata[3:0] == $past(cond[31:28]))
        else $error("status bits not live");
    a_zone_gated: assert property (s_read(ADDR_ZONE)
        ##0 !temperature_zone_charging_enable |=> rdata == 16'h0000)
        else $error("zone shown while disabled");
    a_type_fields: assert property (s_read(ADDR_TYPE_CNT)
        |=> rdata == {4'h0, $past(cond.chem), 4'h0, $past(cond.cells)})
        else $error("type and count misplaced");
    a_dac_code: assert property (s_read(ADDR_ICHG_CODE)
        |=> rdata == {11'h000, $past(cond.charge_current_code)})
        else $error("current code wrong");
    a_ready_flag: assert property (s_read(ADDR_READY) ##0 up_cnt == 2'h3
        |=> rdata == {15'h0000, $past(meas_ready, 2)})
        else $error("ready flag wrong");
    a_alert_cause: assert property ($rose(alert) |-> $past(meas_done))
        else $error("alert without sample");
    a_alert_ready: assert property ($rose(alert) |-> $past(meas_ready, 2))
        else $error("alert before ready");
endmodule

bind ctr_bank ctr_bank_checker #(.N_SET(N_SET)) ctr_bank_checker_i (
    .ref_clk(ref_clk), .nrst(nrst), .req(req), .rdata(rdata),
    .rvalid(rvalid), .meas_done(meas_done), .meas_ready(meas_ready),
    .temperature_zone_charging_enable(temperature_zone_charging_enable),
    .cond(cond), .alert(alert)
);

// *** tb/ctr_host_model.sv ***
// Host model issuing register reads and writes
`timescale 1ns/1ps
module ctr_host_model
    import ctr_pkg::*;
(
    // Clock
    input  wire logic        ref_clk,
    // Register access
    output ctr_req_t         req,
    input  wire logic [15:0] rdata,
    input  wire logic        rvalid
);
    // ****************************************
    // Access tasks
    // ****************************************
    initial req = '0;
    // Released fields carry inverted values so stale data never matches
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge ref_clk);
        req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
        @(posedge ref_clk);
        req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 16'hffff};
        #1;
        d = (rvalid === 1'b1) ? rdata : 'x;
    endtask
    task automatic wait_ready(output logic ok);
        logic [15:0] d;
        ok = 1'b0;
        for (int n = 0; n < 8 && !ok; n++) begin
            rd(ADDR_READY, d);
            ok = (d[0] === 1'b1);
        end
    endtask
endmodule

// *** tb/ctr_bank_tb_top.sv ***
// Self-checking bench for the telemetry register bank
`timescale 1ns/1ps
module ctr_bank_tb_top
    import ctr_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        nrst = 1'b0;
    ctr_req_t    req;
    logic [15:0] rdata;
    logic        rvalid;
    ctr_meas_t   meas = '0;
    ctr_meas_t   m;
    ctr_cond_t   cond = '0;
    ctr_cond_t   rc;
    logic        meas_done = 1'b0;
    logic        meas_ready = 1'b0;
    logic        sr_done = 1'b0;
    logic        zone_en = 1'b0;
    logic        prog_chem = 1'b0;
    logic        alert;
    logic        ok;
    logic [15:0] d;
    logic [15:0] lim [4];
    logic [15:0] ib_old;
    int          seed = 20648;
    int          err_total = 0;
    int          n_checks = 0;
    int          cyc = 0;

    always #4 ref_clk = ~ref_clk;

    ctr_bank ctr_bank_i (
        .ref_clk(ref_clk), .nrst(nrst), .req(req), .rdata(rdata),
        .rvalid(rvalid), .meas(meas), .meas_done(meas_done),
        .meas_ready(meas_ready), .series_r_done(sr_done),
        .temperature_zone_charging_enable(zone_en),
        .programmable_chem(prog_chem), .cond(cond), .alert(alert)
    );
    ctr_host_model ctr_host_model_i (
        .ref_clk(ref_clk), .req(req), .rdata(rdata), .rvalid(rvalid)
    );

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [15:0] exp_zone(logic en, ctr_cond_t c);
        return en ? {13'h0000, c.battery_temperature_zone} : 16'h0000;
    endfunction
    task automatic conclude();
        if (err_total == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] v;
        ctr_host_model_i.rd(a, v);
        check(v, exp);
    endtask
    task automatic sample(input logic [15:0] vb, input logic [15:0] ib);
        m = {vb, 32'($random(seed)), 32'($random(seed)),
             32'($random(seed)), 32'($random(seed))};
        m.bat_i = ib;
        @(posedge ref_clk);
        meas <= m;
        meas_done <= 1'b1;
        @(posedge ref_clk);
        meas_done <= 1'b0;
        #1;
    endtask

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            conclude();
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        rchk(ADDR_BAT_HI, RST_LIMIT_HI);
        rchk(ADDR_IN_HI, RST_LIMIT_HI);
        for (int i = 0; i < 4; i++) begin
            lim[i] = 16'($random(seed));
            ctr_host_model_i.wr(ADDR_BAT_LO + 8'(i), lim[i]);
        end
        for (int i = 0; i < 4; i++) rchk(ADDR_BAT_LO + 8'(i), lim[i]);
        for (int i = 0; i < 2; i++) begin
            @(posedge ref_clk);
            prog_chem <= i[0];
            d = 16'($random(seed));
            ctr_host_model_i.wr(ADDR_SET_LAST, d);
            rchk(ADDR_SET_LAST, i[0] ? d : RST_SETTING);
        end
        // Breach before warm-up must stay silent
        ctr_host_model_i.wr(ADDR_LIM_EN, 16'h0800);
        ctr_host_model_i.wr(ADDR_BAT_LO, 16'h1000);
        sample(16'h0800, 16'h0000);
        check({15'h0000, alert}, 16'h0000);
        rchk(ADDR_READY, 16'h0000);
        @(posedge ref_clk);
        meas_ready <= 1'b1;
        ctr_host_model_i.wait_ready(ok);
        check({15'h0000, ok}, 16'h0001);
        sample(16'h0fff, 16'h0000);
        check({15'h0000, alert}, 16'h0001);
        rchk(ADDR_LIM_ALERT, 16'h0800);
        ctr_host_model_i.wr(ADDR_LIM_ALERT, 16'h0000);
        rchk(ADDR_LIM_ALERT, 16'h0000);
        sample(16'h1000, 16'h0000);
        check({15'h0000, alert}, 16'h0000);
        sample(16'hf000, 16'h0000);
        check({15'h0000, alert}, 16'h0001);
        ctr_host_model_i.wr(ADDR_LIM_EN, 16'h0000);
        rchk(ADDR_LIM_ALERT, 16'h0000);
        // Results, negative current corner, stale latch
        sample(16'($random(seed)), 16'h8000);
        @(posedge ref_clk);
        sr_done <= 1'b1;
        @(posedge ref_clk);
        sr_done <= 1'b0;
        ib_old = m.bat_i;
        sample(16'($random(seed)), 16'($random(seed)));
        ctr_host_model_i.wr(ADDR_BAT_V, ~m.bat_v);
        rchk(ADDR_BAT_V, m.bat_v);
        rchk(ADDR_IN_V, m.in_v);
        rchk(ADDR_SYS_V, m.sys_v);
        rchk(ADDR_BAT_I, m.bat_i);
        rchk(ADDR_IN_I, m.in_i);
        rchk(ADDR_CHIP_TEMP, m.chip_temp);
        rchk(ADDR_NTC, m.therm_ratio);
        rchk(ADDR_SERIES_R, m.series_r);
        rchk(ADDR_BAT_FILT, m.bat_filt);
        rchk(ADDR_R_CURRENT, ib_old);
        rchk(ADDR_RESERVED, UNMAPPED_DATA);
        for (int i = 0; i < 6; i++) begin
            rc = 32'($random(seed));
            @(posedge ref_clk);
            cond <= rc;
            zone_en <= i[0];
            ctr_host_model_i.rd(ADDR_STATUS, d);
            check({12'h000, d[3:0]}, {12'h000, rc[31:28]});
            rchk(ADDR_ZONE, exp_zone(i[0], rc));
            rchk(ADDR_TYPE_CNT, {4'h0, rc.chem, 4'h0, rc.cells});
            rchk(ADDR_ICHG_CODE, {11'h000, rc.charge_current_code});
            rchk(ADDR_VCHG_CODE, {10'h000, rc.charge_voltage_code});
            rchk(ADDR_ILIM_CODE, {10'h000, rc.input_limit_code});
        end
        conclude();
    end
endmodule
